// ### boost_seq_pkg.sv
// Purpose: shared constants for the boost start-up and fault sequencer
// Assumes: clk at 40 MHz; internal oscillator derived from clk
// Notes: times are held in their own unit, cycle counts derived here
//
// Summary of operation
// - enable high shuts everything, opens disconnect switch
// - enable low begins start-up sequence
// - seven states in fixed order, restart on fault
// - soft inrush 2.048ms, switch as current source
// - disconnect switch fully on for 128us
// - soft boost limits 25, 50, 75 percent
// - normal after 8.320ms, limit 100 percent
// - normal holds until disable or fault
// - fault control restarts or shuts down anywhere
// - undervoltage disables I/Os until supply recovers
// - overcurrent disables switches, restarts immediately
// - overvoltage disables switches until output falls
// - over-temperature disables switches until cooled
// - skip pulses while output above target
// - keep minimum off-time every switching period
// - external sync only above about 300kHz
// - sync falling edge starts switch-node drive rising edge
// - internal oscillator runs at 1.0MHz
package boost_seq_pkg;
  // clock rate
  localparam int clk_hz = 40000000;
  // internal oscillator
  localparam int osc_hz = 1000000;
  localparam int osc_div = clk_hz / osc_hz;
  localparam logic [5:0] osc_div_last = 6'(osc_div - 1);
  localparam logic [5:0] osc_on_last = 6'(osc_div / 2 - 1);
  // state lengths in microseconds
  localparam int inrush_us = 2048;
  localparam int dsw_us = 128;
  localparam int boost_us = 2048;
  // state lengths in oscillator ticks (1 tick = 1 us)
  localparam logic [11:0] inrush_last = 12'(inrush_us * osc_hz / 1000000 - 1);
  localparam logic [11:0] dsw_last = 12'(dsw_us * osc_hz / 1000000 - 1);
  localparam logic [11:0] boost_last = 12'(boost_us * osc_hz / 1000000 - 1);
  // minimum switch off-time in ns and in clk cycles (rounded up)
  localparam int min_off_ns = 100;
  localparam logic [5:0] min_off_cyc =
    6'((min_off_ns * (clk_hz / 1000000) + 999) / 1000);
  // sync detector: period above this many clk cycles means too slow
  localparam int sync_min_hz = 300000;
  localparam logic [7:0] sync_max_cyc = 8'(clk_hz / sync_min_hz);
  // current-limit step codes
  localparam logic [1:0] ilim_25 = 2'h0;
  localparam logic [1:0] ilim_50 = 2'h1;
  localparam logic [1:0] ilim_75 = 2'h2;
  localparam logic [1:0] ilim_100 = 2'h3;
  // sequence states
  typedef enum logic [2:0] {
    st_off, st_inrush, st_dsw, st_b25, st_b50, st_b75, st_normal
  } seq_state_t;
endpackage

// ### boost_startup_fault_sequencer.sv
// Purpose: start-up sequencing, fault reaction and switching timing
// Assumes: all pin and comparator inputs are asynchronous to clk
// Notes: the analog loop asks for on-time via pwm_demand_in
`timescale 1ns/1ps
module boost_startup_fault_sequencer (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // pins
  input wire logic chip_enable_low,
  input wire logic sync_clock_in,
  // analog comparator flags
  input wire logic uv_fault_in,
  input wire logic oc_fault_in,
  input wire logic ov_fault_in,
  input wire logic ot_fault_in,
  input wire logic fb_above_target_in,
  input wire logic pwm_demand_in,
  // power stage controls
  output logic io_enable,
  output logic dsw_current_source,
  output logic dsw_full_on,
  output logic switch_node_drive,
  output logic [1:0] ilim_step,
  output logic ext_sync_active
);
  // two-stage synchronisers for all asynchronous inputs
  localparam int n_in = 8;
  logic [n_in-1:0] raw_in;
  logic [n_in-1:0] s1_reg;
  logic [n_in-1:0] s2_reg;
  assign raw_in = {pwm_demand_in, fb_above_target_in, ot_fault_in,
                   ov_fault_in, oc_fault_in, uv_fault_in,
                   sync_clock_in, chip_enable_low};
  genvar gi;
  generate
    for (gi = 0; gi < n_in; gi++) begin : g_sync
      // first stage only feeds the second
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          s1_reg[gi] <= 1'b1;
          s2_reg[gi] <= 1'b1;
        end else begin
          s1_reg[gi] <= raw_in[gi];
          s2_reg[gi] <= s1_reg[gi];
        end
      end
    end
  endgenerate

  // synchronised names
  wire en_low_s = s2_reg[0];
  wire sync_s = s2_reg[1];
  wire uv_s = s2_reg[2];
  wire oc_s = s2_reg[3];
  wire ov_s = s2_reg[4];
  wire ot_s = s2_reg[5];
  wire fb_high_s = s2_reg[6];
  wire demand_s = s2_reg[7];

  // shutdown holds: disable input, undervoltage, overvoltage, hot
  wire disabled = en_low_s;
  wire hold_off = disabled | uv_s | ov_s | ot_s;

  // internal oscillator: divide clk to 1 MHz
  logic [5:0] osc_cnt_reg;
  wire osc_wrap = (osc_cnt_reg == boost_seq_pkg::osc_div_last);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      osc_cnt_reg <= 6'h00;
    end else if (osc_wrap) begin
      osc_cnt_reg <= 6'h00;
    end else begin
      osc_cnt_reg <= osc_cnt_reg + 6'h01;
    end
  end
  wire osc_tick = osc_wrap;  // one 1 us tick for the state timers

  // sync falling-edge detector and frequency detector
  logic sync_d_reg;
  logic [7:0] sync_per_reg;
  logic ext_reg;
  wire sync_fall = sync_d_reg & ~sync_s;
  wire sync_slow = (sync_per_reg >= boost_seq_pkg::sync_max_cyc);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_d_reg <= 1'b1;
      sync_per_reg <= 8'h00;
      ext_reg <= 1'b0;
    end else begin
      sync_d_reg <= sync_s;
      if (sync_fall) begin
        // a fall inside the window proves a fast enough clock
        sync_per_reg <= 8'h00;
        ext_reg <= ~sync_slow;
      end else if (sync_slow) begin
        // no edge for too long: back to the internal oscillator
        ext_reg <= 1'b0;
      end else begin
        sync_per_reg <= sync_per_reg + 8'h01;
      end
    end
  end

  // start-up state machine
  boost_seq_pkg::seq_state_t state_reg, state_next;
  logic [11:0] tmr_reg;
  logic [11:0] tmr_last;
  wire tmr_done = osc_tick & (tmr_reg == tmr_last);

  // length of the current state in oscillator ticks
  always_comb begin
    case (state_reg)
      boost_seq_pkg::st_inrush: tmr_last = boost_seq_pkg::inrush_last;
      boost_seq_pkg::st_dsw: tmr_last = boost_seq_pkg::dsw_last;
      default: tmr_last = boost_seq_pkg::boost_last;
    endcase
  end

  // next state: faults force off or a fresh start
  always_comb begin
    state_next = state_reg;
    if (hold_off) begin
      state_next = boost_seq_pkg::st_off;
    end else if (oc_s) begin
      state_next = boost_seq_pkg::st_off;         // restart next cycle
    end else begin
      case (state_reg)
        boost_seq_pkg::st_off: state_next = boost_seq_pkg::st_inrush;
        boost_seq_pkg::st_inrush:
          if (tmr_done) state_next = boost_seq_pkg::st_dsw;
        boost_seq_pkg::st_dsw:
          if (tmr_done) state_next = boost_seq_pkg::st_b25;
        boost_seq_pkg::st_b25:
          if (tmr_done) state_next = boost_seq_pkg::st_b50;
        boost_seq_pkg::st_b50:
          if (tmr_done) state_next = boost_seq_pkg::st_b75;
        boost_seq_pkg::st_b75:
          if (tmr_done) state_next = boost_seq_pkg::st_normal;
        boost_seq_pkg::st_normal: state_next = state_reg;
        default: state_next = boost_seq_pkg::st_off;
      endcase
    end
  end

  // state and timer registers; timer clears on every state change
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= boost_seq_pkg::st_off;
      tmr_reg <= 12'h000;
    end else begin
      state_reg <= state_next;
      if (state_next != state_reg) begin
        tmr_reg <= 12'h000;
      end else if (osc_tick) begin
        tmr_reg <= tmr_reg + 12'h001;
      end
    end
  end

  // state decode
  wire in_inrush = (state_reg == boost_seq_pkg::st_inrush);
  wire in_boost = (state_reg == boost_seq_pkg::st_b25) |
                  (state_reg == boost_seq_pkg::st_b50) |
                  (state_reg == boost_seq_pkg::st_b75) |
                  (state_reg == boost_seq_pkg::st_normal);
  wire dsw_on = (state_reg == boost_seq_pkg::st_dsw) | in_boost;

  // current-limit step per state
  logic [1:0] ilim_next;
  always_comb begin
    case (state_reg)
      boost_seq_pkg::st_b50: ilim_next = boost_seq_pkg::ilim_50;
      boost_seq_pkg::st_b75: ilim_next = boost_seq_pkg::ilim_75;
      boost_seq_pkg::st_normal: ilim_next = boost_seq_pkg::ilim_100;
      default: ilim_next = boost_seq_pkg::ilim_25;
    endcase
  end

  // switching period start: sync fall or internal oscillator
  wire period_start = ext_reg ? sync_fall : osc_wrap;
  // internal phase on-window ends half way through the period
  wire int_on_end = (osc_cnt_reg == boost_seq_pkg::osc_on_last);

  // switch-node drive with pulse skip and minimum off-time
  logic sw_reg;
  logic [5:0] off_cnt_reg;
  wire off_ok = (off_cnt_reg >= boost_seq_pkg::min_off_cyc);
  wire sw_allowed = in_boost & ~fb_high_s & ~hold_off & ~oc_s;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sw_reg <= 1'b0;
      off_cnt_reg <= 6'h00;
    end else begin
      if (!sw_allowed) begin
        sw_reg <= 1'b0;
      end else if (period_start & off_ok & demand_s) begin
        sw_reg <= 1'b1;
      end else if (sw_reg & (~demand_s | (~ext_reg & int_on_end))) begin
        sw_reg <= 1'b0;
      end else if (sw_reg & ext_reg & sync_s) begin
        // external phase: on-window ends when sync rises, which keeps
        // the high half of the sync period as off-time
        sw_reg <= 1'b0;
      end
      // count off-time so each period keeps the minimum
      if (sw_reg) begin
        off_cnt_reg <= 6'h00;
      end else if (!off_ok) begin
        off_cnt_reg <= off_cnt_reg + 6'h01;
      end
    end
  end

  // registered outputs
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      io_enable <= 1'b0;
      dsw_current_source <= 1'b0;
      dsw_full_on <= 1'b0;
      ilim_step <= boost_seq_pkg::ilim_25;
      ext_sync_active <= 1'b0;
    end else begin
      io_enable <= ~disabled & ~uv_s;
      dsw_current_source <= in_inrush & ~oc_s;
      dsw_full_on <= dsw_on & ~oc_s;
      ilim_step <= ilim_next;
      ext_sync_active <= ext_reg;
    end
  end
  assign switch_node_drive = sw_reg;
endmodule // boost_startup_fault_sequencer

// ### boost_seq_props.sv
// Purpose: port checks for the boost start-up sequencer
// Assumes: one clock domain, arst_n active low
// Notes: the long inrush time is checked through a counter
`timescale 1ns/1ps
module boost_seq_props (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // pin and comparator inputs
  input wire logic chip_enable_low,
  input wire logic uv_fault_in,
  input wire logic oc_fault_in,
  input wire logic ov_fault_in,
  input wire logic ot_fault_in,
  input wire logic fb_above_target_in,
  // power stage controls
  input wire logic io_enable,
  input wire logic dsw_current_source,
  input wire logic dsw_full_on,
  input wire logic switch_node_drive,
  input wire logic [1:0] ilim_step
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic [16:0] inrush_reg; // cycles with the current source on
  // count the inrush cycles, cleared whenever the source is off
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      inrush_reg <= 17'h0;
    end else begin
      inrush_reg <= dsw_current_source ? inrush_reg + 17'h1 : 17'h0;
    end
  end
  // all power drives released
  sequence off_s;
    !dsw_current_source && !dsw_full_on && !switch_node_drive;
  endsequence
  en_off_a: assert property (chip_enable_low[*6] |->
    off_s ##0 !io_enable) else $error("outputs on while disabled");
  uv_io_a: assert property (uv_fault_in[*6] |->
    off_s ##0 !io_enable) else $error("outputs on in undervoltage");
  fault_off_a: assert property (
    (oc_fault_in || ov_fault_in || ot_fault_in)[*6] |-> off_s)
    else $error("switches on during a fault");
  dsw_mode_a: assert property (
    !(dsw_current_source && dsw_full_on))
    else $error("switch both source and fully on");
  skip_pulse_a: assert property (fb_above_target_in[*6] |->
    !switch_node_drive) else $error("switched above target");
  min_off_a: assert property ($fell(switch_node_drive) |->
    !switch_node_drive[*4]) else $error("off-time too short");
  ilim_order_a: assert property (
    $changed(ilim_step) && ilim_step != 2'h0 |->
    ilim_step == $past(ilim_step) + 2'h1) else $error("ilim step skipped");
  inrush_len_a: assert property (
    $fell(dsw_current_source) && dsw_full_on |->
    inrush_reg >= 17'd81880 && inrush_reg <= 17'd81960)
    else $error("inrush length wrong");
endmodule // boost_seq_props
bind boost_startup_fault_sequencer boost_seq_props props_inst (
  .clk(clk), .arst_n(arst_n), .chip_enable_low(chip_enable_low),
  .uv_fault_in(uv_fault_in), .oc_fault_in(oc_fault_in),
  .ov_fault_in(ov_fault_in), .ot_fault_in(ot_fault_in),
  .fb_above_target_in(fb_above_target_in), .io_enable(io_enable),
  .dsw_current_source(dsw_current_source), .dsw_full_on(dsw_full_on),
  .switch_node_drive(switch_node_drive), .ilim_step(ilim_step));

// ### host_model.sv
// Purpose: host driving the enable pin and the sync clock
// Assumes: requests change just after clk rises
// Notes: the sync pin is driven high while sync_req is low
`timescale 1ns/1ps
module host_model #(parameter int sync_div = 40) (
  // bench requests
  input wire logic clk,
  input wire logic en_req,
  input wire logic sync_req,
  // pins
  output logic chip_enable_low,
  output logic sync_clock_in
);
  logic [7:0] div_reg; // sync period counter
  initial begin
    chip_enable_low = 1'b1;
    sync_clock_in = 1'b1;
    div_reg = 8'h0;
  end
  // enable follows the request, sync runs at 1 MHz when asked
  always @(posedge clk) begin
    chip_enable_low <= !en_req;
    div_reg <= (div_reg == 8'(sync_div - 1)) ? 8'h0 : div_reg + 8'h1;
    sync_clock_in <= !sync_req || (div_reg >= 8'(sync_div / 2));
  end
endmodule // host_model

// ### test_boost_startup_fault_sequencer.sv
// Purpose: self-checking bench for the boost start-up sequencer
// Assumes: 40 MHz clk, full state times
// Notes: the run ends in inrush after the overcurrent restart
`timescale 1ns/1ps
module test_boost_startup_fault_sequencer;
  typedef struct packed {
    logic [3:0] flt; // uv, oc, ov, ot
    logic dis; // enable released instead of a fault
    logic io; // io_enable expected
  } row_t;
  row_t rows [5] = '{'{4'h8, 1'b0, 1'b0}, '{4'h4, 1'b0, 1'b1},
    '{4'h2, 1'b0, 1'b1}, '{4'h1, 1'b0, 1'b1}, '{4'h0, 1'b1, 1'b0}};
  logic clk, arst_n, en_req, sync_req, fb, dem, prev;
  logic chip_enable_low, sync_clock_in, io, cs, full, sw, xs;
  logic [3:0] flt; // fault flags, same order as a row
  logic [3:0] flags; // waitable outputs
  logic [1:0] ilim;
  int failures, check_count, n, since;
  assign flags = {full, sw, xs, cs};
  host_model host_model_inst (.clk(clk), .en_req(en_req),
    .sync_req(sync_req), .chip_enable_low(chip_enable_low),
    .sync_clock_in(sync_clock_in));
  boost_startup_fault_sequencer boost_startup_fault_sequencer_inst (
    .clk(clk), .arst_n(arst_n), .chip_enable_low(chip_enable_low),
    .sync_clock_in(sync_clock_in), .uv_fault_in(flt[3]),
    .oc_fault_in(flt[2]), .ov_fault_in(flt[1]), .ot_fault_in(flt[0]),
    .fb_above_target_in(fb), .pwm_demand_in(dem), .io_enable(io),
    .dsw_current_source(cs), .dsw_full_on(full),
    .switch_node_drive(sw), .ilim_step(ilim), .ext_sync_active(xs));
  task automatic check(input string nm, input logic [3:0] seen,
    input logic [3:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic stop_test;
    if (failures == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  // bounded wait for one flag, cycles left in n
  task automatic wait_for(input int b, input int lim);
    n = 0;
    while (flags[b] !== 1'b1 && n < lim) begin
      @(negedge clk);
      n++;
    end
    if (n >= lim) begin
      failures++;
      stop_test();
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    {arst_n, en_req, sync_req, fb, flt} = 8'h0;
    {dem, failures, check_count} = {1'b1, 64'h0};
    cyc(20);
    arst_n <= 1'b1;
    cyc(10);
    @(negedge clk);
    check("off", {io, cs, full, sw}, 4'h0);
    // each row: start, apply the fault, release it
    foreach (rows[i]) begin
      @(posedge clk);
      en_req <= 1'b1;
      cyc(10);
      @(negedge clk);
      check("start", {io, cs}, 4'h3);
      @(posedge clk);
      flt <= rows[i].flt;
      en_req <= !rows[i].dis;
      cyc(10);
      @(negedge clk);
      check("fault", {io, cs, sw}, {1'b0, rows[i].io, 2'h0});
      @(posedge clk);
      flt <= 4'h0;
      en_req <= 1'b1;
      cyc(10);
      @(negedge clk);
      check("restart", cs, 4'h1);
    end
    @(posedge clk);
    en_req <= 1'b0;
    cyc(10);
    en_req <= 1'b1;
    wait_for(3, 90000);
    check("inrush", 4'(n >= 81880 && n <= 81980), 4'h1);
    check("dsw", {cs, sw}, 4'h0);
    wait_for(2, 5300);
    check("dsw_len", 4'(n >= 5080), 4'h1);
    check("ilim", ilim, 4'h0);
    @(posedge clk);
    fb <= 1'b1;
    cyc(8);
    since = 0;
    repeat (80) begin
      @(negedge clk);
      since += sw;
    end
    check("skip", 4'(since > 0), 4'h0);
    @(posedge clk);
    {fb, sync_req} <= 2'h1;
    wait_for(1, 400);
    @(posedge clk);
    dem <= 1'b0;
    cyc(20);
    dem <= 1'b1;
    {n, since, prev} = {32'h0, 32'd99, sync_clock_in};
    while (sw !== 1'b1 && n < 100) begin
      @(negedge clk);
      since = (prev && !sync_clock_in) ? 0 : since + 1;
      prev = sync_clock_in;
      n++;
    end
    if (n >= 100) begin
      failures++;
      stop_test();
    end
    check("sync_lead", 4'(since <= 6), 4'h1);
    sync_req <= 1'b0;
    cyc(200);
    @(negedge clk);
    check("int_osc", xs, 4'h0);
    @(posedge clk);
    flt <= 4'h4;
    cyc(6);
    flt <= 4'h0;
    cyc(10);
    @(negedge clk);
    check("oc_restart", {cs, full}, 4'h2);
    stop_test();
  end
endmodule // test_boost_startup_fault_sequencer
